// file: design/can_rx_header_cfg.svh
// Overview of operation
// - id high byte holds id bits 10..3 standard, or 28..21 extended.
// - id low bits 7..5 hold id bits 2..0 standard, or 20..18 extended.
// - id low bit 4 reads the received substitute remote flag on extended frames.
// - id low bit 3 set for an extended frame, cleared for standard.
// - id low bits 1..0 hold id 17..16; ext high holds id 15..8.
// - ext low byte holds extended id bits 7..0, msb in bit 7.
// - id low bit 2 and length bit 7 always read zero.
// - length bit 6 reads 1 for a remote request frame, else 0.
// - length bits 5..4 are the reserved control bits and read zero.
// - length bits 3..0 hold the length code; above 1000 is invalid.
`ifndef CAN_RX_HEADER_CFG_SVH
`define CAN_RX_HEADER_CFG_SVH

`define REG_ID_HIGH      3'h0
`define REG_ID_LOW       3'h1
`define REG_EXT_HIGH     3'h2
`define REG_EXT_LOW      3'h3
`define REG_LEN_CTL      3'h4

`define LOW_SUBREM_BIT   4
`define LOW_EXT_BIT      3
`define LEN_REMOTE_BIT   6

`define LOW_WR_MASK      8'hfb
`define LEN_WR_MASK      8'h4f
`define FULL_WR_MASK     8'hff

`define HDR_RESET_BYTE   8'h00
`define MAX_LENGTH_CODE  4'h8

`endif

// file: design/can_rx_header_pkg.sv
package can_rx_header_pkg;

	typedef logic [7:0] hdr_byte_t;

	typedef struct packed {
		hdr_byte_t idHigh;
		hdr_byte_t idLow;
		hdr_byte_t extHigh;
		hdr_byte_t extLow;
		hdr_byte_t lenCtl;
	} header_bytes_t;

	typedef logic [2:0] reg_addr_t;

endpackage : can_rx_header_pkg

// file: design/rxhdr_load_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rxhdr_load_if;
	import can_rx_header_pkg::*;

	logic          load;
	header_bytes_t bytes;

	modport source (output load, output bytes);
	modport sink   (input load, input bytes);

endinterface : rxhdr_load_if

`default_nettype wire

// file: design/rxhdr_frame_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_header_cfg.svh"

module rxhdr_frame_capture (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	// accepted frame from the bus side
	input  wire logic                  frameLoad,
	input  wire logic                  frameExtended,
	input  wire logic                  frameRemote,
	input  wire logic                  frameSubRemote,
	input  wire logic [28:0]           frameId,
	input  wire logic [3:0]            frameLengthCode,
	// packed header toward storage
	rxhdr_load_if.source               ld
);
	import can_rx_header_pkg::*;

	logic          next_load;
	header_bytes_t next_bytes;

	always_comb
	begin
		next_load = frameLoad;
		next_bytes = '0;
		if (frameExtended)
		begin
			next_bytes.idHigh = frameId[28:21];
			next_bytes.idLow[7:5] = frameId[20:18];
			next_bytes.idLow[1:0] = frameId[17:16];
			next_bytes.extHigh = frameId[15:8];
			next_bytes.extLow = frameId[7:0];
			next_bytes.idLow[`LOW_SUBREM_BIT] = frameSubRemote;
		end
		else
		begin
			next_bytes.idHigh = frameId[10:3];
			next_bytes.idLow[7:5] = frameId[2:0];
		end
		next_bytes.idLow[`LOW_EXT_BIT] = frameExtended;
		next_bytes.lenCtl[`LEN_REMOTE_BIT] = frameRemote;
		next_bytes.lenCtl[3:0] = frameLengthCode;
		// reserved control bits of the frame are dropped here
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ld.load <= 1'b0;
			ld.bytes <= '0;
		end
		else
		begin
			ld.load <= next_load;
			ld.bytes <= next_bytes;
		end
	end

endmodule : rxhdr_frame_capture

`default_nettype wire

// file: design/rxhdr_read_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_header_cfg.svh"

module rxhdr_read_port (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	// read request
	input  wire logic                        regRd,
	input  wire can_rx_header_pkg::reg_addr_t regAddr,
	input  wire can_rx_header_pkg::header_bytes_t hdr,
	// read answer, one cycle later
	output logic [7:0]                       regRdData
);
	import can_rx_header_pkg::*;

	logic [7:0] next_regRdData;

	function automatic logic [7:0] pick(input reg_addr_t a, input header_bytes_t h);
		case (a)
			`REG_ID_HIGH:  pick = h.idHigh;
			`REG_ID_LOW:   pick = h.idLow;
			`REG_EXT_HIGH: pick = h.extHigh;
			`REG_EXT_LOW:  pick = h.extLow;
			`REG_LEN_CTL:  pick = h.lenCtl;
			default:       pick = 8'h00;
		endcase
	endfunction : pick

	always_comb
	begin
		// data held only for the cycle after the strobe
		next_regRdData = regRd ? pick(regAddr, hdr) : 8'h00;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			regRdData <= 8'h00;
		else
			regRdData <= next_regRdData;
	end

endmodule : rxhdr_read_port

`default_nettype wire

// file: design/can_rx_header.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_header_cfg.svh"

module can_rx_header (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	// register port
	input  wire can_rx_header_pkg::reg_addr_t regAddr,
	input  wire logic [7:0]                  regWrData,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic [7:0]                       regRdData,
	// accepted frame from the bus side
	input  wire logic                        frameLoad,
	input  wire logic                        frameExtended,
	input  wire logic                        frameRemote,
	input  wire logic                        frameSubRemote,
	input  wire logic [28:0]                 frameId,
	input  wire logic [3:0]                  frameLengthCode,
	// header status
	output logic                             headerLoaded,
	output logic [3:0]                       dataByteCount,
	output logic                             lengthInvalid
);
	import can_rx_header_pkg::*;

	rxhdr_load_if ld ();

	header_bytes_t hdr;
	header_bytes_t next_hdr;
	logic          next_headerLoaded;
	logic [3:0]    next_dataByteCount;
	logic          next_lengthInvalid;

	// codes above eight are kept as written but flagged; count clamps to 0
	function automatic logic codeBad(input logic [3:0] code);
		codeBad = (code > `MAX_LENGTH_CODE);
	endfunction : codeBad

	rxhdr_frame_capture u_capture (
		.mclk            (mclk),
		.rst_b           (rst_b),
		.frameLoad       (frameLoad),
		.frameExtended   (frameExtended),
		.frameRemote     (frameRemote),
		.frameSubRemote  (frameSubRemote),
		.frameId         (frameId),
		.frameLengthCode (frameLengthCode),
		.ld              (ld.source)
	);

	always_comb
	begin
		next_hdr = hdr;
		if (ld.load)
			// whole header at once; a same-cycle software write is lost
			next_hdr = ld.bytes;
		else if (regWr)
		begin
			case (regAddr)
				`REG_ID_HIGH:  next_hdr.idHigh = regWrData & `FULL_WR_MASK;
				`REG_ID_LOW:   next_hdr.idLow = regWrData & `LOW_WR_MASK;
				`REG_EXT_HIGH: next_hdr.extHigh = regWrData & `FULL_WR_MASK;
				`REG_EXT_LOW:  next_hdr.extLow = regWrData & `FULL_WR_MASK;
				`REG_LEN_CTL:  next_hdr.lenCtl = regWrData & `LEN_WR_MASK;
				default:       next_hdr = hdr;
			endcase
		end
		next_headerLoaded = ld.load;
		next_lengthInvalid = codeBad(next_hdr.lenCtl[3:0]);
		next_dataByteCount = next_lengthInvalid ? 4'h0 : next_hdr.lenCtl[3:0];
	end

	// contents are undefined to software; zero only so outputs are defined
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hdr <= {5{`HDR_RESET_BYTE}};
			headerLoaded <= 1'b0;
			dataByteCount <= 4'h0;
			lengthInvalid <= 1'b0;
		end
		else
		begin
			hdr <= next_hdr;
			headerLoaded <= next_headerLoaded;
			dataByteCount <= next_dataByteCount;
			lengthInvalid <= next_lengthInvalid;
		end
	end

	rxhdr_read_port u_read (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.regRd     (regRd),
		.regAddr   (regAddr),
		.hdr       (hdr),
		.regRdData (regRdData)
	);

	// frame to storage takes two edges: capture, then store
	chk_std_high_byte: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && !frameExtended |-> ##2 hdr.idHigh == $past(frameId[10:3], 2))
		else $error("standard id high byte wrong");

	chk_ext_high_byte: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && frameExtended |-> ##2 hdr.idHigh == $past(frameId[28:21], 2))
		else $error("extended id top byte wrong");

	chk_low_top_bits: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad |-> ##2 hdr.idLow[7:5] ==
			($past(frameExtended, 2) ? $past(frameId[20:18], 2) : $past(frameId[2:0], 2)))
		else $error("id low bits 7..5 wrong");

	chk_subst_remote: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad |-> ##2 hdr.idLow[`LOW_SUBREM_BIT] == ($past(frameSubRemote, 2)
			&& $past(frameExtended, 2)))
		else $error("substitute remote bit wrong");

	chk_ext_flag: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad |-> ##2 hdr.idLow[`LOW_EXT_BIT] == $past(frameExtended, 2))
		else $error("extended flag wrong");

	chk_mid_id_bits: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && frameExtended |-> ##2 hdr.idLow[1:0] == $past(frameId[17:16], 2)
			&& hdr.extHigh == $past(frameId[15:8], 2))
		else $error("extended mid bits wrong");

	chk_ext_low_byte: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && frameExtended |-> ##2 hdr.extLow == $past(frameId[7:0], 2))
		else $error("extended low byte wrong");

	chk_unimpl_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		regRd && (regAddr == `REG_ID_LOW || regAddr == `REG_LEN_CTL)
			|=> regRdData[2] == 1'b0 || $past(regAddr) == `REG_LEN_CTL)
		else $error("unimplemented id low bit read as one");

	chk_len_top_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		regRd && regAddr == `REG_LEN_CTL |=> regRdData[7] == 1'b0)
		else $error("length bit 7 read as one");

	chk_remote_flag: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad |-> ##2 hdr.lenCtl[`LEN_REMOTE_BIT] == $past(frameRemote, 2))
		else $error("remote request bit wrong");

	chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		regWr && regAddr == `REG_LEN_CTL ##1 regRd && regAddr == `REG_LEN_CTL
			|=> regRdData[5:4] == 2'b00)
		else $error("reserved control bits read nonzero");

	chk_length_code: assert property (@(posedge mclk) disable iff (!rst_b)
		frameLoad |-> ##2 hdr.lenCtl[3:0] == $past(frameLengthCode, 2)
			##1 lengthInvalid == (hdr.lenCtl[3:0] > 4'h8) || $changed(hdr))
		else $error("length code or invalid flag wrong");

	chk_write_back: assert property (@(posedge mclk) disable iff (!rst_b)
		regWr && regAddr == `REG_EXT_LOW && !ld.load ##1 regRd
			&& regAddr == `REG_EXT_LOW && !ld.load |=> regRdData == $past(regWrData, 2))
		else $error("written byte not read back");

	chk_atomic_load: assert property (@(posedge mclk) disable iff (!rst_b)
		ld.load |=> hdr == $past(ld.bytes) && headerLoaded)
		else $error("header not loaded as one unit");

	cov_std_frame: cover property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && !frameExtended ##2 headerLoaded);

	cov_ext_remote: cover property (@(posedge mclk) disable iff (!rst_b)
		frameLoad && frameExtended && frameRemote ##2 headerLoaded);

	cov_bad_length: cover property (@(posedge mclk) disable iff (!rst_b)
		lengthInvalid);

	cov_write_read: cover property (@(posedge mclk) disable iff (!rst_b)
		regWr ##1 regRd);

endmodule : can_rx_header

`default_nettype wire

// file: test/can_node_model.sv
`timescale 1ns/1ps
`default_nettype none

module can_node_model (
	// clock
	input  wire logic        mclk,
	// accepted frame toward the buffer
	output var  logic        frameLoad,
	output var  logic        frameExtended,
	output var  logic        frameRemote,
	output var  logic        frameSubRemote,
	output var  logic [28:0] frameId,
	output var  logic [3:0]  frameLengthCode
);
	initial
	begin
		frameLoad       = 1'b0;
		frameExtended   = 1'b0;
		frameRemote     = 1'b0;
		frameSubRemote  = 1'b0;
		frameId         = 29'h0;
		frameLengthCode = 4'h0;
	end

	// one accepted frame, then the fields flip so stale values never look valid
	task automatic send(input logic ext, input logic rem, input logic sub,
		input logic [28:0] id, input logic [3:0] code);
		@(posedge mclk);
		frameLoad       <= 1'b1;
		frameExtended   <= ext;
		frameRemote     <= rem;
		frameSubRemote  <= sub;
		frameId         <= id;
		frameLengthCode <= code;
		@(posedge mclk);
		frameLoad       <= 1'b0;
		frameExtended   <= ~ext;
		frameRemote     <= ~rem;
		frameSubRemote  <= ~sub;
		frameId         <= ~id;
		frameLengthCode <= ~code;
	endtask : send
endmodule : can_node_model

`default_nettype wire

// file: test/can_rx_header_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_header_cfg.svh"

module can_rx_header_test;
	import can_rx_header_pkg::*;

	logic        mclk;
	logic        rst_b;
	reg_addr_t   regAddr;
	logic [7:0]  regWrData;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regRdData;
	logic        frameLoad;
	logic        frameExtended;
	logic        frameRemote;
	logic        frameSubRemote;
	logic [28:0] frameId;
	logic [3:0]  frameLengthCode;
	logic        headerLoaded;
	logic [3:0]  dataByteCount;
	logic        lengthInvalid;
	int          err_count;
	int          n_checks;

	can_rx_header i_dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.frameLoad(frameLoad), .frameExtended(frameExtended), .frameRemote(frameRemote),
		.frameSubRemote(frameSubRemote), .frameId(frameId),
		.frameLengthCode(frameLengthCode), .headerLoaded(headerLoaded),
		.dataByteCount(dataByteCount), .lengthInvalid(lengthInvalid));

	can_node_model i_node (.mclk(mclk), .frameLoad(frameLoad),
		.frameExtended(frameExtended), .frameRemote(frameRemote),
		.frameSubRemote(frameSubRemote), .frameId(frameId),
		.frameLengthCode(frameLengthCode));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input reg_addr_t a, input logic [7:0] d);
		@(posedge mclk);
		regWr     <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr     <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input reg_addr_t a, input logic [7:0] exp);
		@(posedge mclk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd   <= 1'b0;
		#1;
		chk($sformatf("reg%0d", a), exp, regRdData);
	endtask : rd

	// expected header worked out from the field layout
	function automatic header_bytes_t expect_hdr(input logic e, input logic r, input logic s,
		input logic [28:0] id, input logic [3:0] c);
		header_bytes_t h;
		h.idHigh  = e ? id[28:21] : id[10:3];
		h.idLow   = {e ? id[20:18] : id[2:0], s & e, e, 1'b0, e ? id[17:16] : 2'b00};
		h.extHigh = e ? id[15:8] : 8'h00;
		h.extLow  = e ? id[7:0] : 8'h00;
		h.lenCtl  = {1'b0, r, 2'b00, c};
		return h;
	endfunction : expect_hdr

	task automatic frame_case(input int i);
		logic [28:0]   id;
		header_bytes_t h;
		int            k;
		id = {i[3:0], 25'h0}^(29'h15a5c3e7 + 29'(i * 29'h0331));
		h  = expect_hdr(i[0], i[1], i[2], id, i[3:0]);
		i_node.send(i[0], i[1], i[2], id, i[3:0]);
		k = 0;
		while (headerLoaded !== 1'b1 && k < 10)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (k >= 10)
		begin
			err_count++;
			tally_and_finish();
		end
		chk("count", (i <= 8) ? 8'(i) : 8'h00, {4'h0, dataByteCount});
		chk("invalid", {7'h0, i > 8}, {7'h0, lengthInvalid});
		rd(`REG_ID_HIGH, h.idHigh);
		rd(`REG_ID_LOW, h.idLow);
		rd(`REG_EXT_HIGH, h.extHigh);
		rd(`REG_EXT_LOW, h.extLow);
		rd(`REG_LEN_CTL, h.lenCtl);
	endtask : frame_case

	initial
	begin
		logic [7:0] m [5];
		err_count = 0;
		n_checks  = 0;
		rst_b     = 1'b0;
		regAddr   = 3'h0;
		regWrData = 8'h00;
		regWr     = 1'b0;
		regRd     = 1'b0;
		m = '{`FULL_WR_MASK, `LOW_WR_MASK, `FULL_WR_MASK, `FULL_WR_MASK, `LEN_WR_MASK};
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		// every length code, both frame kinds, all flag mixes
		for (int i = 0; i < 16; i++)
			frame_case(i);
		// software side: implemented bits read back ff, then 5a, reserved ones stay zero
		for (int a = 0; a < 5; a++)
		begin
			wr(3'(a), 8'hff);
			rd(3'(a), m[a]);
			wr(3'(a), 8'h5a);
			rd(3'(a), 8'h5a & m[a]);
		end
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00);
		rd(`REG_LEN_CTL, 8'h5a & m[4]);
		tally_and_finish();
	end
endmodule : can_rx_header_test

`default_nettype wire
